// File: aec_ctrl.sv
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "aec_defs.svh"
module aec_ctrl (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  // Register port
  input  wire aec_pkg::aec_addr_t  reg_addr,
  input  wire aec_pkg::aec_byte_t  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output aec_pkg::aec_byte_t       reg_rdata,
  // Converter inputs
  input  wire aec_pkg::aec_byte_t  vout_code,
  input  wire logic                hs_pwm_req,
  input  wire logic                ls_pwm_req,
  input  wire logic                cycle_start,
  input  wire logic                ls_zero_cross,
  // Gate drives
  output logic                     high_side_gate_drive,
  output logic                     low_side_gate_drive,
  // Driver and sense pin configuration
  output logic                     diode_emul_sel,
  output logic                     hs_drive_strength,
  output logic                     sense_pos_pullup_en,
  output logic                     sense_neg_pulldown_en,
  // Analog block enables
  output logic                     slope_comp_bypass,
  output logic                     current_meas_en,
  output logic                     temp_sensor_en,
  output logic                     eff_circuit_en,
  output logic                     signal_chain_en,
  output logic                     eff_meas_go,
  // Detected conditions
  output logic                     ov_event,
  output logic                     uv_event
);
  import aec_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  aec_top_st_t st_reg;
  aec_top_st_t st_next;
  logic        ov_flag;
  logic        uv_flag;
  logic        kill;
  logic        term_now;
  aec_byte_t   status;

  aec_dt_if hs_dt ();
  aec_dt_if ls_dt ();

  // ----------------------------------------------------------------
  // Voltage monitor
  // ----------------------------------------------------------------
  aec_vmon u_vmon (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .vout_code (vout_code),
    .ov_thr    (st_reg.ov_thr),
    .uv_thr    (st_reg.uv_thr),
    .ov_en     (st_reg.block[`AEC_BE_OV_DET]), // RL1
    .uv_en     (st_reg.block[`AEC_BE_UV_DET]), // RL2
    .ov_flag   (ov_flag),
    .uv_flag   (uv_flag)
  );

  // ----------------------------------------------------------------
  // Dead-time insertion, one sequencer per driver
  // ----------------------------------------------------------------
  // Bypass bits steer each sequencer directly
  assign hs_dt.req    = hs_pwm_req;
  assign hs_dt.bypass = st_reg.periph[`AEC_PE_HS_BYPASS]; // RL10
  assign hs_dt.delay  = st_reg.deadtime[`AEC_DT_HS_MSB:`AEC_DT_HS_LSB];
  assign ls_dt.req    = ls_pwm_req;
  assign ls_dt.bypass = st_reg.periph[`AEC_PE_LS_BYPASS]; // RL10
  assign ls_dt.delay  = st_reg.deadtime[`AEC_DT_LS_MSB:`AEC_DT_LS_LSB];

  aec_deadtime u_hs_dt (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .dt       (hs_dt.dly)
  );

  aec_deadtime u_ls_dt (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .dt       (ls_dt.dly)
  );

  // ----------------------------------------------------------------
  // Protection and rectification
  // ----------------------------------------------------------------
  // Accelerators act on the registered flags so a noisy compare
  // cannot glitch the drives mid-cycle
  assign kill = (ov_flag && st_reg.periph[`AEC_PE_OV_ACCEL]) || // RL12
                (uv_flag && st_reg.periph[`AEC_PE_UV_ACCEL]);   // RL11

  // Diode emulation latches the low side off at zero current
  assign term_now = st_reg.periph[`AEC_PE_DIODE_EMUL] && // RL9
                    (st_reg.ls_term ||
                     (ls_zero_cross && st_reg.ls_drv));

  // Read-only view of the block's live state
  assign status = {3'h0, st_reg.ls_term, st_reg.ls_drv,
                   st_reg.hs_drv, uv_flag, ov_flag};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next         = st_reg;
    st_next.meas_go = 1'b0;
    st_next.rdata   = `AEC_RST_BYTE;
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `AEC_OFF_PERIPH: begin
          st_next.periph = reg_wdata; // RL13
        end
        `AEC_OFF_BLOCK: begin
          st_next.block = reg_wdata;
          // Only a 0 to 1 write of the start bit launches a run
          st_next.meas_go = reg_wdata[`AEC_BE_MEAS_START] && // RL3
                            !st_reg.block[`AEC_BE_MEAS_START];
        end
        `AEC_OFF_OV_THR: begin
          st_next.ov_thr = reg_wdata;
        end
        `AEC_OFF_UV_THR: begin
          st_next.uv_thr = reg_wdata;
        end
        `AEC_OFF_DEADTIME: begin
          st_next.deadtime = reg_wdata;
        end
        default: begin
          st_next.meas_go = 1'b0;
        end
      endcase
    end
    // Register reads; unmapped addresses return zero
    if (reg_rd) begin
      case (reg_addr)
        `AEC_OFF_PERIPH:   st_next.rdata = st_reg.periph; // RL13
        `AEC_OFF_BLOCK:    st_next.rdata = st_reg.block;
        `AEC_OFF_OV_THR:   st_next.rdata = st_reg.ov_thr;
        `AEC_OFF_UV_THR:   st_next.rdata = st_reg.uv_thr;
        `AEC_OFF_DEADTIME: st_next.rdata = st_reg.deadtime;
        `AEC_OFF_STATUS:   st_next.rdata = status;
        default:           st_next.rdata = `AEC_RST_BYTE;
      endcase
    end
    // Gate drives: accelerators override everything
    st_next.hs_drv  = hs_dt.drive && !kill;             // RL11 RL12
    st_next.ls_drv  = ls_dt.drive && !kill && !term_now; // RL9
    // Termination holds until the next switching cycle begins;
    // in synchronous mode it is never set
    st_next.ls_term = term_now && !cycle_start; // RL9
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_reg <= '{`AEC_RST_PERIPH, `AEC_RST_BLOCK, `AEC_RST_THR,
                  `AEC_RST_THR, `AEC_RST_DEADTIME, `AEC_RST_BYTE,
                  1'b0, 1'b0, 1'b0, 1'b0}; // RL13
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata             = st_reg.rdata;
  assign high_side_gate_drive  = st_reg.hs_drv;
  assign low_side_gate_drive   = st_reg.ls_drv;
  assign diode_emul_sel        = st_reg.periph[`AEC_PE_DIODE_EMUL];  // RL9
  // Set selects the weaker 1A high-side driver
  assign hs_drive_strength     = st_reg.periph[`AEC_PE_HS_STRENGTH]; // RL14
  assign sense_pos_pullup_en   = st_reg.periph[`AEC_PE_POS_PULL];    // RL14
  assign sense_neg_pulldown_en = st_reg.periph[`AEC_PE_NEG_PULL];    // RL14
  // Block enables go straight to the analog macros
  assign slope_comp_bypass     = st_reg.block[`AEC_BE_SLOPE_BYP];    // RL4
  assign current_meas_en       = st_reg.block[`AEC_BE_CURR_MEAS];    // RL5
  assign temp_sensor_en        = st_reg.block[`AEC_BE_TEMP_SENS];    // RL6
  assign eff_circuit_en        = st_reg.block[`AEC_BE_EFF_CIRC];     // RL7
  assign signal_chain_en       = st_reg.block[`AEC_BE_SIG_CHAIN];    // RL8
  assign eff_meas_go           = st_reg.meas_go;                     // RL3
  assign ov_event              = ov_flag;
  assign uv_event              = uv_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_periph_wr;
    reg_wr && reg_addr == `AEC_OFF_PERIPH;
  endsequence

  sequence s_periph_rd;
    reg_rd && reg_addr == `AEC_OFF_PERIPH;
  endsequence

  sequence s_start_rise;
    reg_wr && reg_addr == `AEC_OFF_BLOCK &&
    reg_wdata[`AEC_BE_MEAS_START] && !st_reg.block[`AEC_BE_MEAS_START];
  endsequence

  sequence s_block_wr;
    reg_wr && reg_addr == `AEC_OFF_BLOCK;
  endsequence

  a_periph_readback: assert property ( // RL13
    s_periph_wr ##1 s_periph_rd |=> reg_rdata == $past(reg_wdata, 2))
    else $error("peripheral enable read back wrong");
  a_meas_go_pulse: assert property ( // RL3
    s_start_rise |=> eff_meas_go ##1 !eff_meas_go)
    else $error("measurement start pulse missing or long");
  a_block_outputs: assert property ( // RL8
    s_block_wr |=> signal_chain_en == $past(reg_wdata[`AEC_BE_SIG_CHAIN])
                   && temp_sensor_en == $past(reg_wdata[`AEC_BE_TEMP_SENS])
                   && current_meas_en == $past(reg_wdata[`AEC_BE_CURR_MEAS]))
    else $error("block enable outputs do not follow write");
  a_ov_accel_kill: assert property ( // RL12
    ov_flag && st_reg.periph[`AEC_PE_OV_ACCEL]
    |=> !high_side_gate_drive && !low_side_gate_drive)
    else $error("overvoltage accelerator did not kill drives");
  a_uv_accel_kill: assert property ( // RL11
    uv_flag && st_reg.periph[`AEC_PE_UV_ACCEL]
    |=> !high_side_gate_drive && !low_side_gate_drive)
    else $error("undervoltage accelerator did not kill drives");
  a_diode_cutoff: assert property ( // RL9
    diode_emul_sel && ls_zero_cross && low_side_gate_drive && !cycle_start
    |=> !low_side_gate_drive ##1 !low_side_gate_drive)
    else $error("diode emulation did not end low side drive");
  a_sync_no_term: assert property ( // RL9
    !diode_emul_sel |=> !st_reg.ls_term)
    else $error("synchronous mode terminated low side");
endmodule
`default_nettype wire

// File: aec_defs.svh
// Function
// RL1: Clearing the overvoltage enable bit turns overvoltage detection off and the threshold is ignored; setting it turns detection on.
// RL2: Clearing the undervoltage enable bit turns undervoltage detection off and the threshold is ignored; setting it turns detection on.
// RL3: Setting the efficiency measurement start bit begins a relative efficiency measurement.
// RL4: Setting the slope compensation bypass bit bypasses slope compensation, and it is normally set.
// RL5: Setting the current measurement enable bit turns on peak current measurement, and it is normally set.
// RL6: The temperature sensor runs only while its enable bit is set.
// RL7: The efficiency circuit enable bit powers the efficiency circuitry, apart from the start bit.
// RL8: Setting the signal chain enable bit enables the voltage control path, and it is normally set.
// RL9: The diode emulation bit picks the rectification mode: emulation ends the low-side drive at zero current, synchronous keeps it until the next cycle.
// RL10: A cleared dead-time bypass bit adds the programmed dead time to that driver's turn-on edge; a set bit skips the delay.
// RL11: With the undervoltage accelerator on, an undervoltage forces both gate drives low at once.
// RL12: With the overvoltage accelerator on, an overvoltage forces both gate drives low at once.
// RL13: The peripheral enable register is eight read/write bits, zero at reset, laid out mode, strength, two bypasses, two pulls, two accelerators from bit 7 down.
// RL14: The strength bit picks 1A high-side drive when set and 2A when clear, and each pull bit enables its weak pull when set.
`ifndef AEC_DEFS_SVH
`define AEC_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define AEC_ADDR_W        3
`define AEC_DATA_W        8
`define AEC_DLY_W         4
`define AEC_OFF_PERIPH    3'h0
`define AEC_OFF_BLOCK     3'h1
`define AEC_OFF_OV_THR    3'h2
`define AEC_OFF_UV_THR    3'h3
`define AEC_OFF_DEADTIME  3'h4
`define AEC_OFF_STATUS    3'h5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AEC_RST_PERIPH    8'h00
`define AEC_RST_BLOCK     8'h00
`define AEC_RST_THR       8'h00
`define AEC_RST_DEADTIME  8'h00
`define AEC_RST_BYTE      8'h00
`define AEC_DLY_ZERO      4'h0
`define AEC_DLY_ONE       4'h1

// ----------------------------------------------------------------
// Peripheral enable fields
// ----------------------------------------------------------------
`define AEC_PE_DIODE_EMUL 7
`define AEC_PE_HS_STRENGTH 6
`define AEC_PE_HS_BYPASS  5
`define AEC_PE_LS_BYPASS  4
`define AEC_PE_NEG_PULL   3
`define AEC_PE_POS_PULL   2
`define AEC_PE_UV_ACCEL   1
`define AEC_PE_OV_ACCEL   0

// ----------------------------------------------------------------
// Block enable fields
// ----------------------------------------------------------------
`define AEC_BE_OV_DET     7
`define AEC_BE_UV_DET     6
`define AEC_BE_MEAS_START 5
`define AEC_BE_SLOPE_BYP  4
`define AEC_BE_CURR_MEAS  3
`define AEC_BE_TEMP_SENS  2
`define AEC_BE_EFF_CIRC   1
`define AEC_BE_SIG_CHAIN  0

// ----------------------------------------------------------------
// Dead-time config fields: high side above, low side below
// ----------------------------------------------------------------
`define AEC_DT_HS_MSB     7
`define AEC_DT_HS_LSB     4
`define AEC_DT_LS_MSB     3
`define AEC_DT_LS_LSB     0

`endif

// File: aec_pkg.sv
`default_nettype none
`include "aec_defs.svh"
package aec_pkg;

  typedef logic [`AEC_DATA_W-1:0] aec_byte_t;
  typedef logic [`AEC_ADDR_W-1:0] aec_addr_t;
  typedef logic [`AEC_DLY_W-1:0]  aec_delay_t;

  // Dead-time sequencer states
  typedef enum logic [1:0] {
    AEC_DT_IDLE,
    AEC_DT_WAIT,
    AEC_DT_ON
  } aec_dt_state_t;

  typedef struct packed {
    aec_dt_state_t state;
    aec_delay_t    cnt;
    logic          drive;
  } aec_dt_st_t;

  typedef struct packed {
    logic ov_flag;
    logic uv_flag;
  } aec_vmon_st_t;

  typedef struct packed {
    aec_byte_t periph;
    aec_byte_t block;
    aec_byte_t ov_thr;
    aec_byte_t uv_thr;
    aec_byte_t deadtime;
    aec_byte_t rdata;
    logic      meas_go;
    logic      hs_drv;
    logic      ls_drv;
    logic      ls_term;
  } aec_top_st_t;

endpackage
`default_nettype wire

// File: aec_dt_if.sv
`timescale 1ns/1ps
`default_nettype none
// Turn-on request, bypass and delay in; delayed drive back out
interface aec_dt_if;
  logic                  req;
  logic                  bypass;
  aec_pkg::aec_delay_t   delay;
  logic                  drive;
  modport ctrl (output req, output bypass, output delay, input drive);
  modport dly  (input req, input bypass, input delay, output drive);
endinterface
`default_nettype wire

// File: aec_deadtime.sv
`timescale 1ns/1ps
`default_nettype none
`include "aec_defs.svh"
module aec_deadtime (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Request and delayed drive
  aec_dt_if.dly     dt
);
  import aec_pkg::*;

  aec_dt_st_t st_reg;
  aec_dt_st_t st_next;

  // Only the turn-on edge is delayed; turn-off is never held back
  always_comb begin
    st_next = st_reg;
    case (st_reg.state)
      AEC_DT_IDLE: begin
        st_next.drive = 1'b0;
        if (dt.req) begin
          if (dt.bypass || dt.delay == `AEC_DLY_ZERO) begin // RL10
            st_next.state = AEC_DT_ON;
            st_next.drive = 1'b1;
          end else begin
            st_next.state = AEC_DT_WAIT; // RL10
            st_next.cnt   = dt.delay;
          end
        end
      end
      AEC_DT_WAIT: begin
        if (!dt.req) begin
          st_next.state = AEC_DT_IDLE;
        end else if (st_reg.cnt == `AEC_DLY_ONE) begin
          st_next.state = AEC_DT_ON;
          st_next.drive = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt - `AEC_DLY_ONE;
        end
      end
      AEC_DT_ON: begin
        if (!dt.req) begin
          st_next.state = AEC_DT_IDLE;
          st_next.drive = 1'b0;
        end
      end
      default: begin
        st_next.state = AEC_DT_IDLE;
        st_next.drive = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_reg <= '{AEC_DT_IDLE, `AEC_DLY_ZERO, 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign dt.drive = st_reg.drive;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_dt_bypass_on: assert property ( // RL10
    st_reg.state == AEC_DT_IDLE && dt.req && dt.bypass |=> dt.drive)
    else $error("bypassed driver did not turn on next cycle");
  a_dt_delay_hold: assert property ( // RL10
    st_reg.state == AEC_DT_IDLE && dt.req && !dt.bypass &&
    dt.delay != `AEC_DLY_ZERO |=> !dt.drive)
    else $error("dead time not inserted on turn-on");
  a_dt_fast_off: assert property (
    !dt.req |=> !dt.drive)
    else $error("drive stayed on after request dropped");
endmodule
`default_nettype wire

// File: aec_vmon.sv
`timescale 1ns/1ps
`default_nettype none
`include "aec_defs.svh"
module aec_vmon (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  // Measured output and limits
  input  wire aec_pkg::aec_byte_t  vout_code,
  input  wire aec_pkg::aec_byte_t  ov_thr,
  input  wire aec_pkg::aec_byte_t  uv_thr,
  input  wire logic                ov_en,
  input  wire logic                uv_en,
  // Detected conditions
  output logic                     ov_flag,
  output logic                     uv_flag
);
  import aec_pkg::*;

  aec_vmon_st_t st_reg;
  aec_vmon_st_t st_next;

  // A disabled comparator never looks at its threshold
  always_comb begin
    st_next.ov_flag = ov_en && (vout_code > ov_thr); // RL1
    st_next.uv_flag = uv_en && (vout_code < uv_thr); // RL2
  end

  // Flags registered so the gate kill sees a clean level
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_reg <= '{1'b0, 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ov_flag = st_reg.ov_flag;
  assign uv_flag = st_reg.uv_flag;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_ov_off_quiet: assert property (!ov_en |=> !ov_flag) // RL1
    else $error("overvoltage flagged while detection disabled");
  a_ov_trip_seen: assert property ( // RL1
    ov_en && vout_code > ov_thr |=> ov_flag)
    else $error("overvoltage missed");
  a_uv_off_quiet: assert property (!uv_en |=> !uv_flag) // RL2
    else $error("undervoltage flagged while detection disabled");
  a_uv_trip_seen: assert property ( // RL2
    uv_en && vout_code < uv_thr |=> uv_flag)
    else $error("undervoltage missed");
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "aec_defs.svh"
module testbench;
  import aec_pkg::*;
  // ------------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------------
  logic      core_clk, rst_b, reg_wr, reg_rd;
  aec_addr_t reg_addr;
  aec_byte_t reg_wdata, reg_rdata, vout_code, rd_val;
  logic      hs_pwm_req, ls_pwm_req, cycle_start, ls_zero_cross;
  logic      high_side_gate_drive, low_side_gate_drive, diode_emul_sel;
  logic      hs_drive_strength, sense_pos_pullup_en, sense_neg_pulldown_en;
  logic      slope_comp_bypass, current_meas_en, temp_sensor_en;
  logic      eff_circuit_en, signal_chain_en, eff_meas_go, ov_event;
  logic      uv_event;
  int        err_count, tests_run;

  aec_ctrl aec_ctrl_inst (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .vout_code, .hs_pwm_req, .ls_pwm_req, .cycle_start,
    .ls_zero_cross, .high_side_gate_drive, .low_side_gate_drive,
    .diode_emul_sel, .hs_drive_strength, .sense_pos_pullup_en,
    .sense_neg_pulldown_en, .slope_comp_bypass, .current_meas_en,
    .temp_sensor_en, .eff_circuit_en, .signal_chain_en, .eff_meas_go,
    .ov_event, .uv_event);

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Let n edges pass, then step clear of the edge before sampling
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic reg_write(input aec_addr_t a, input aec_byte_t d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input aec_addr_t a, output aec_byte_t d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic test_reset;
    for (int i = 0; i < 8; i++) begin
      reg_read(i[2:0], rd_val);
      check("reset readback", rd_val, 8'h00);
    end
    tick(1);
    check("rdata idle", reg_rdata, 8'h00);
    $display("test_reset done");
  endtask

  task automatic test_periph;
    aec_byte_t pats [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
                             8'h02, 8'h01, 8'hff, 8'h00};
    foreach (pats[i]) begin
      reg_write(`AEC_OFF_PERIPH, pats[i]);
      check("pe outputs", {4'h0, diode_emul_sel, hs_drive_strength,
        sense_neg_pulldown_en, sense_pos_pullup_en},
        {4'h0, pats[i][7], pats[i][6], pats[i][3], pats[i][2]});
      reg_read(`AEC_OFF_PERIPH, rd_val);
      check("pe readback", rd_val, pats[i]);
    end
    // Write then read with no idle cycle between the strobes
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= `AEC_OFF_PERIPH;
    reg_wdata <= 8'h5c;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check("pe back to back", reg_rdata, 8'h5c);
    // Status is read-only and index 7 is unmapped
    reg_write(`AEC_OFF_STATUS, 8'hff);
    reg_read(`AEC_OFF_STATUS, rd_val);
    check("status write ignored", rd_val, 8'h00);
    reg_write(3'h7, 8'h5a);
    reg_read(3'h7, rd_val);
    check("unmapped read", rd_val, 8'h00);
    $display("test_periph done");
  endtask

  task automatic test_block;
    aec_byte_t v;
    for (int i = 0; i < 8; i++) begin
      v = 8'h01 << i;
      reg_write(`AEC_OFF_BLOCK, v);
      check("meas pulse", {7'h0, eff_meas_go}, {7'h0, v[5]});
      check("block outputs", {3'h0, slope_comp_bypass, current_meas_en,
        temp_sensor_en, eff_circuit_en, signal_chain_en}, {3'h0, v[4:0]});
      reg_read(`AEC_OFF_BLOCK, rd_val);
      check("block readback", rd_val, v);
    end
    // Start pulse lasts one cycle and needs a 0 to 1 change
    reg_write(`AEC_OFF_BLOCK, 8'h26);
    check("meas go", {7'h0, eff_meas_go}, 8'h01);
    tick(1);
    check("meas one cycle", {7'h0, eff_meas_go}, 8'h00);
    reg_write(`AEC_OFF_BLOCK, 8'h22);
    check("meas no restart", {7'h0, eff_meas_go}, 8'h00);
    check("circuit apart", {7'h0, eff_circuit_en}, 8'h01);
    check("temp off", {7'h0, temp_sensor_en}, 8'h00);
    $display("test_block done");
  endtask

  task automatic test_detect;
    reg_write(`AEC_OFF_OV_THR, 8'h80);
    reg_write(`AEC_OFF_UV_THR, 8'h40);
    reg_write(`AEC_OFF_BLOCK, 8'h00);
    @(posedge core_clk);
    vout_code <= 8'h90;
    tick(3);
    check("ov disabled", {7'h0, ov_event}, 8'h00);
    reg_write(`AEC_OFF_BLOCK, 8'h80);
    tick(3);
    check("ov enabled", {7'h0, ov_event}, 8'h01);
    @(posedge core_clk);
    vout_code <= 8'h80;
    tick(3);
    check("ov at limit", {7'h0, ov_event}, 8'h00);
    @(posedge core_clk);
    vout_code <= 8'h20;
    tick(3);
    check("uv disabled", {7'h0, uv_event}, 8'h00);
    reg_write(`AEC_OFF_BLOCK, 8'hc0);
    tick(3);
    check("uv enabled", {6'h0, ov_event, uv_event}, 8'h01);
    $display("test_detect done");
  endtask

  task automatic test_accel;
    reg_write(`AEC_OFF_PERIPH, 8'h30);
    @(posedge core_clk);
    vout_code  <= 8'h60;
    hs_pwm_req <= 1'b1;
    tick(1);
    check("hs bypass early", {7'h0, high_side_gate_drive}, 8'h00);
    tick(1);
    check("hs bypass on", {7'h0, high_side_gate_drive}, 8'h01);
    @(posedge core_clk);
    vout_code <= 8'h90;
    tick(3);
    check("ov no accel", {6'h0, ov_event, high_side_gate_drive}, 8'h03);
    reg_write(`AEC_OFF_PERIPH, 8'h31);
    tick(3);
    check("ov accel", {6'h0, high_side_gate_drive, low_side_gate_drive},
      8'h00);
    @(posedge core_clk);
    vout_code <= 8'h20;
    reg_write(`AEC_OFF_PERIPH, 8'h32);
    tick(3);
    check("uv accel", {6'h0, high_side_gate_drive, uv_event}, 8'h01);
    @(posedge core_clk);
    hs_pwm_req <= 1'b0;
    vout_code  <= 8'h60;
    tick(3);
    $display("test_accel done");
  endtask

  // Delay counts are short so the edge figures stay exact
  task automatic test_deadtime;
    reg_write(`AEC_OFF_PERIPH, 8'h00);
    reg_write(`AEC_OFF_DEADTIME, 8'h32);
    @(posedge core_clk);
    hs_pwm_req <= 1'b1;
    tick(4);
    check("hs delayed low", {7'h0, high_side_gate_drive}, 8'h00);
    tick(1);
    check("hs delayed on", {7'h0, high_side_gate_drive}, 8'h01);
    @(posedge core_clk);
    hs_pwm_req <= 1'b0;
    tick(1);
    check("hs release hold", {7'h0, high_side_gate_drive}, 8'h01);
    tick(1);
    check("hs released", {7'h0, high_side_gate_drive}, 8'h00);
    @(posedge core_clk);
    ls_pwm_req <= 1'b1;
    tick(3);
    check("ls delayed low", {7'h0, low_side_gate_drive}, 8'h00);
    tick(1);
    check("ls delayed on", {7'h0, low_side_gate_drive}, 8'h01);
    @(posedge core_clk);
    ls_pwm_req <= 1'b0;
    tick(3);
    $display("test_deadtime done");
  endtask

  task automatic test_diode;
    reg_write(`AEC_OFF_PERIPH, 8'h90);
    @(posedge core_clk);
    ls_pwm_req <= 1'b1;
    tick(2);
    check("ls on", {7'h0, low_side_gate_drive}, 8'h01);
    @(posedge core_clk);
    ls_zero_cross <= 1'b1;
    @(posedge core_clk);
    ls_zero_cross <= 1'b0;
    tick(3);
    check("ls cut off", {7'h0, low_side_gate_drive}, 8'h00);
    reg_read(`AEC_OFF_STATUS, rd_val);
    check("status cutoff", rd_val, 8'h10);
    @(posedge core_clk);
    cycle_start <= 1'b1;
    @(posedge core_clk);
    cycle_start <= 1'b0;
    tick(3);
    check("ls new cycle", {7'h0, low_side_gate_drive}, 8'h01);
    reg_write(`AEC_OFF_PERIPH, 8'h10);
    @(posedge core_clk);
    ls_zero_cross <= 1'b1;
    tick(3);
    check("ls synchronous", {7'h0, low_side_gate_drive}, 8'h01);
    @(posedge core_clk);
    ls_zero_cross <= 1'b0;
    ls_pwm_req    <= 1'b0;
    tick(2);
    $display("test_diode done");
  endtask

  // ------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // A hang counts as a mismatch and still reaches the verdict
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("Run timed out");
    wrap_up();
  end

  initial begin
    err_count = 0;
    tests_run = 0;
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, vout_code} = '0;
    {hs_pwm_req, ls_pwm_req, cycle_start, ls_zero_cross} = '0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    test_reset();
    test_periph();
    test_block();
    test_detect();
    test_accel();
    test_deadtime();
    test_diode();
    wrap_up();
  end
endmodule
`default_nettype wire
